/* File: common/mhb_consts.svh */
`ifndef MHB_CONSTS_SVH
`define MHB_CONSTS_SVH

// Transmit buffer sizing, in bytes.
`define MHB_BUF_CAP 8'h96
`define MHB_START_LEN 8'h1A
// Timing: clock rate in kHz and the wake limit in ms (120 ms).
`define MHB_CLK_KHZ 32'hC350
`define MHB_WAKE_MAX_MS 32'h78
// Command execution time in clock cycles.
`define MHB_CMD_EXEC_CYC 8'h10
// Register byte offsets.
`define MHB_ADR_CTRL 4'h0
`define MHB_ADR_STAT 4'h4
`define MHB_ADR_EVT 4'h8
`define MHB_ADR_DROP 4'hC
// Control fields and reset value.
`define MHB_CTRL_RESP 0
`define MHB_CTRL_FLOW 1
`define MHB_CTRL_RST 2'h1
// Event fields.
`define MHB_EVT_OVF 0
`define MHB_EVT_CERR 1
`endif

/* File: common/mhb_pkg.sv */
package mhb_pkg;
  // Power state, Gray coded along run, down, wake.
  typedef enum logic [1:0]
  {
    MHB_RUN = 2'h0,
    MHB_DOWN = 2'h1,
    MHB_WAKE = 2'h3
  } mhb_pwr_t;
endpackage : mhb_pkg

/* File: core/mhb_top.sv */
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`include "mhb_consts.svh"
module mhb_top #(
  parameter int WAKE_CYC = `MHB_WAKE_MAX_MS * `MHB_CLK_KHZ
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic host_valid_i,
  input wire logic [7:0] host_data_i,
  output logic input_permit_o,
  output logic [7:0] tx_data_o,
  output logic tx_valid_o,
  input wire logic tx_ready_i,
  input wire logic tx_done_i,
  input wire logic tx_ok_i,
  output logic resp_valid_o,
  output logic resp_ok_o,
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_code_i,
  output logic command_ack_response_o,
  output logic [7:0] ack_code_o,
  input wire logic shut_n_i,
  output logic powerdown_o,
  output logic ready_o
);

  mhb_pkg::mhb_pwr_t pwr_r;
  mhb_pkg::mhb_pwr_t pwr_nxt;
  logic [22:0] wake_cnt_r;
  logic [7:0] mem_r [0:149];
  logic [7:0] wr_r;
  logic [7:0] rd_r;
  logic [7:0] count_r;
  logic sending_r;
  logic [1:0] ctrl_r;
  logic [1:0] evt_r;
  logic [15:0] drop_cnt_r;
  logic [7:0] tx_data_r;
  logic busy_r;
  logic [7:0] exec_cnt_r;
  logic [7:0] cmd_r;
  logic ack_r;
  logic [7:0] ack_code_r;
  logic resp_valid_r;
  logic resp_ok_r;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;

  // Decode of the power state and the buffer conditions.
  wire running = (pwr_r == mhb_pkg::MHB_RUN);
  wire buf_full = (count_r == `MHB_BUF_CAP);
  wire buf_empty = (count_r == 8'h00);
  wire push = running && host_valid_i && !buf_full;
  wire drop = running && host_valid_i && buf_full;
  wire pop = tx_valid_o && tx_ready_i;
  wire [7:0] wr_inc = (wr_r == `MHB_BUF_CAP - 8'h01) ? 8'h00 : wr_r + 8'h01;
  wire [7:0] rd_inc = (rd_r == `MHB_BUF_CAP - 8'h01) ? 8'h00 : rd_r + 8'h01;
  wire [7:0] rd_next = pop ? rd_inc : rd_r;
  wire resp_en = ctrl_r[`MHB_CTRL_RESP];
  wire flow_en = ctrl_r[`MHB_CTRL_FLOW];

  // Wishbone decode; every access is acked, unmapped offsets read zero.
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_r;
  wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  wire wr_ctrl = wb_wr && (wb_adr_i == `MHB_ADR_CTRL);
  wire wr_evt = wb_wr && (wb_adr_i == `MHB_ADR_EVT);
  wire [31:0] stat_word = {20'h00000, ready_o, busy_r, powerdown_o, sending_r, count_r};
  wire [31:0] rd_word = (wb_adr_i == `MHB_ADR_CTRL) ? {30'h0, ctrl_r} :
                        (wb_adr_i == `MHB_ADR_STAT) ? stat_word :
                        (wb_adr_i == `MHB_ADR_EVT) ? {30'h0, evt_r} :
                        (wb_adr_i == `MHB_ADR_DROP) ? {16'h0000, drop_cnt_r} : 32'h00000000;

  // Command decode: a new command is taken only in normal operation.
  wire cmd_take = running && cmd_valid_i && !busy_r;
  wire cmd_clash = running && cmd_valid_i && busy_r;
  wire exec_end = busy_r && (exec_cnt_r == `MHB_CMD_EXEC_CYC - 8'h01);

  // Next power state; a low shutdown pin always wins.
  always_comb
  begin
    pwr_nxt = pwr_r;
    case (pwr_r)
      mhb_pkg::MHB_RUN:
      begin
        if (!shut_n_i)
          pwr_nxt = mhb_pkg::MHB_DOWN;
      end
      mhb_pkg::MHB_DOWN:
      begin
        if (shut_n_i)
          pwr_nxt = mhb_pkg::MHB_WAKE;
      end
      mhb_pkg::MHB_WAKE:
      begin
        if (!shut_n_i)
          pwr_nxt = mhb_pkg::MHB_DOWN;
        else if (wake_cnt_r == 23'(WAKE_CYC - 1))
          pwr_nxt = mhb_pkg::MHB_RUN;
      end
      default:
      begin
        pwr_nxt = mhb_pkg::MHB_DOWN;
      end
    endcase
  end

  // The wake counter only runs while the state stays in wake, so it never passes its end value.
  wire wake_hold = (pwr_r == mhb_pkg::MHB_WAKE) && (pwr_nxt == mhb_pkg::MHB_WAKE);

  // Power state and wake counter; the wake time is WAKE_CYC cycles, by default the limit.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_r <= mhb_pkg::MHB_RUN;
      wake_cnt_r <= 23'h000000;
    end
    else
    begin
      pwr_r <= pwr_nxt;
      wake_cnt_r <= wake_hold ? wake_cnt_r + 23'h000001 : 23'h000000;
    end
  end

  // Buffer storage holds no reset, since only the pointers say what is valid.
  always_ff @(posedge clk_i)
  begin
    if (push)
      mem_r[wr_r] <= host_data_i;
  end

  // Pointers and fill level; power-down flushes everything buffered.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !running)
    begin
      wr_r <= 8'h00;
      rd_r <= 8'h00;
      count_r <= 8'h00;
    end
    else
    begin
      if (push)
        wr_r <= wr_inc;
      rd_r <= rd_next;
      count_r <= count_r + {7'h00, push} - {7'h00, pop};
    end
  end

  // Transmission starts above the threshold and then drains the buffer empty.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !running)
      sending_r <= 1'b0;
    else if (count_r > `MHB_START_LEN)
      sending_r <= 1'b1;
    else if (buf_empty || (pop && count_r == 8'h01))
      sending_r <= 1'b0;
  end

  // Output byte is registered; it tracks the head of the buffer.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      tx_data_r <= 8'h00;
    else if (push && (count_r == {7'h00, pop}))
      tx_data_r <= host_data_i;
    else
      tx_data_r <= mem_r[rd_next];
  end

  // Control register; defaults return while powered down so settings are lost.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || pwr_r == mhb_pkg::MHB_DOWN)
      ctrl_r <= `MHB_CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= wb_dat_i[1:0];
  end

  // Sticky events; write one to clear, and a new event wins over the clear.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      evt_r <= 2'h0;
    else
    begin
      evt_r[`MHB_EVT_OVF] <= drop || (evt_r[`MHB_EVT_OVF] && !(wr_evt && wb_dat_i[`MHB_EVT_OVF]));
      evt_r[`MHB_EVT_CERR] <= cmd_clash ||
                              (evt_r[`MHB_EVT_CERR] && !(wr_evt && wb_dat_i[`MHB_EVT_CERR]));
    end
  end

  // Dropped byte count saturates rather than wrapping to a misleading small value.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      drop_cnt_r <= 16'h0000;
    else if (drop && drop_cnt_r != 16'hFFFF)
      drop_cnt_r <= drop_cnt_r + 16'h0001;
  end

  // Command sequencer; a clashing command leaves the running one untouched.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !running)
    begin
      busy_r <= 1'b0;
      exec_cnt_r <= 8'h00;
      cmd_r <= 8'h00;
    end
    else if (cmd_take)
    begin
      busy_r <= 1'b1;
      exec_cnt_r <= 8'h00;
      cmd_r <= cmd_code_i;
    end
    else if (exec_end)
      busy_r <= 1'b0;
    else if (busy_r)
      exec_cnt_r <= exec_cnt_r + 8'h01;
  end

  // Acknowledge pulse is sent only when responses are enabled.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
      ack_code_r <= 8'h00;
    end
    else
    begin
      ack_r <= exec_end && resp_en && running;
      if (exec_end)
        ack_code_r <= cmd_r;
    end
  end

  // Per-message radio result is passed to the host when responses are enabled in normal operation.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      resp_valid_r <= 1'b0;
      resp_ok_r <= 1'b0;
    end
    else
    begin
      resp_valid_r <= tx_done_i && resp_en && running;
      if (tx_done_i)
        resp_ok_r <= tx_ok_i;
    end
  end

  // Bus answer one cycle after the request, released the cycle after.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_r <= 1'b0;
      wb_dat_r <= 32'h00000000;
    end
    else
    begin
      wb_ack_r <= wb_req;
      wb_dat_r <= rd_word;
    end
  end

  // Output drive; the permit is held low only under flow control or outside normal operation.
  assign input_permit_o = running && (!flow_en || !buf_full);
  assign tx_valid_o = sending_r && !buf_empty;
  assign tx_data_o = tx_data_r;
  assign resp_valid_o = resp_valid_r;
  assign resp_ok_o = resp_ok_r;
  assign command_ack_response_o = ack_r;
  assign ack_code_o = ack_code_r;
  assign powerdown_o = (pwr_r == mhb_pkg::MHB_DOWN);
  assign ready_o = running;
  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;

  // Checks on the buffer, commands and power sequencing.
  a_buf_cap_held: assert property (@(posedge clk_i) disable iff (rst_i) count_r <= `MHB_BUF_CAP)
    else $error("Buffer level above capacity.");

  a_tx_start_len: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(sending_r) |-> $past(count_r) > `MHB_START_LEN)
    else $error("Transmission began at or below the start length.");

  a_tx_starts_soon: assert property (@(posedge clk_i) disable iff (rst_i)
    (running && count_r > `MHB_START_LEN && shut_n_i) |=> sending_r)
    else $error("Transmission did not start above the start length.");

  a_drop_when_full: assert property (@(posedge clk_i) disable iff (rst_i)
    drop |=> evt_r[`MHB_EVT_OVF] && (count_r == $past(count_r) - {7'h00, $past(pop)}) || !running)
    else $error("Full buffer accepted a byte or missed the overflow flag.");

  a_resp_gated: assert property (@(posedge clk_i) disable iff (rst_i)
    resp_valid_o |-> $past(tx_done_i) && $past(resp_en) && resp_ok_o == $past(tx_ok_i))
    else $error("Response without an enabled radio result.");

  a_cmd_clash_err: assert property (@(posedge clk_i) disable iff (rst_i)
    cmd_clash && shut_n_i |=> evt_r[`MHB_EVT_CERR] && $stable(cmd_r))
    else $error("Early command was not flagged or was taken.");

  a_pd_entry: assert property (@(posedge clk_i) disable iff (rst_i)
    !shut_n_i |=> powerdown_o && !ready_o)
    else $error("Low shutdown pin did not enter power-down.");

  a_cfg_cleared: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(powerdown_o) |-> ctrl_r == `MHB_CTRL_RST)
    else $error("Settings survived power-down.");

  a_wake_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    wake_cnt_r <= 23'(WAKE_CYC - 1))
    else $error("Wake period ran past its limit.");

endmodule : mhb_top

/* File: sim/mhb_host_model.sv */
`timescale 1ns/100ps
module mhb_host_model
(
  input wire logic clk_i,
  input wire logic permit_i,
  output logic valid_o,
  output logic [7:0] data_o
);
  // Sends one byte a cycle; the permit is sampled mid-cycle so the host pauses promptly.
  task automatic burst(input logic [7:0] q[$]);
    logic ok;
    while (q.size() > 0)
    begin
      @(negedge clk_i);
      ok = permit_i;
      @(posedge clk_i);
      valid_o <= ok;
      data_o <= ok ? q.pop_front() : ~data_o;
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
    data_o <= ~data_o;
  endtask : burst
  // An idle cycle in a burst shows the inverse of the line's previous value, so a second one in a row repeats the last byte.
  initial
  begin
    valid_o = 1'b0;
    data_o = 8'h00;
  end
endmodule : mhb_host_model

/* File: sim/tb_top.sv */
`timescale 1ns/100ps
`include "mhb_consts.svh"
module tb_top;
  localparam int WAKE = 50;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, tx_ready = 1'b0, tx_done = 1'b0, tx_ok = 1'b0;
  logic cmd_valid = 1'b0, shut_n = 1'b1, host_valid, wb_ack, ack, tx_valid, resp_valid, resp_ok;
  logic permit, pdown, rdy;
  logic [3:0] wb_adr = 4'h0, wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd, lf = 32'h14E4;
  logic [7:0] cmd_code = 8'h00, host_data, tx_data, ack_code;
  logic [7:0] exp_tx[$], exp_ack[$], bq[$];
  logic exp_resp[$];
  int n_fail = 0, comparisons = 0, cyc_n = 0, n;
  mhb_top #(.WAKE_CYC(WAKE)) i_mhb_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .host_valid_i(host_valid), .host_data_i(host_data),
    .input_permit_o(permit), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
    .tx_done_i(tx_done), .tx_ok_i(tx_ok), .resp_valid_o(resp_valid), .resp_ok_o(resp_ok),
    .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .command_ack_response_o(ack),
    .ack_code_o(ack_code), .shut_n_i(shut_n), .powerdown_o(pdown), .ready_o(rdy));
  mhb_host_model i_mhb_host_model (.clk_i(clk_i), .permit_i(permit), .valid_o(host_valid),
    .data_o(host_data));
  // Free-running 50 MHz clock.
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  // Classic single Wishbone cycle; waits for ack however long it takes, the bench timeout ends a hang.
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= s;
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
  endtask : wb
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string what);
    wb(1'b0, a, 32'h0, 4'hF);
    chk(what, e, rd);
  endtask : rdc
  // Each result seen on the outputs retires the oldest note; a result with no note fails.
  always @(posedge clk_i)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      n_fail++;
      complete_run();
    end
    if (tx_valid && tx_ready)
      chk("tx_data", exp_tx.size() ? exp_tx.pop_front() : 8'hXX, tx_data);
    if (resp_valid)
      chk("resp_ok", exp_resp.size() ? exp_resp.pop_front() : 1'bX, resp_ok);
    if (ack)
      chk("ack_code", exp_ack.size() ? exp_ack.pop_front() : 8'hXX, ack_code);
  end
  // Main sequence: registers, buffer, responses, commands, power-down.
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`MHB_ADR_CTRL, 32'h1, "ctrl");
    rdc(`MHB_ADR_STAT, 32'h800, "stat");
    wb(1'b1, `MHB_ADR_CTRL, 32'h2, 4'h0);
    rdc(`MHB_ADR_CTRL, 32'h1, "ctrl_sel");
    rdc(4'h1, 32'h0, "unmapped");
    $display("test registers done");
    for (int i = 0; i < 153; i++)
    begin
      lf = lfsr(lf);
      bq.push_back(lf[7:0]);
      if (i < 150)
        exp_tx.push_back(lf[7:0]);
    end
    i_mhb_host_model.burst(bq[0:25]);
    repeat (2) @(posedge clk_i);
    chk("idle_26", 1'b0, tx_valid);
    i_mhb_host_model.burst(bq[26:26]);
    repeat (2) @(posedge clk_i);
    chk("start_27", 1'b1, tx_valid);
    i_mhb_host_model.burst(bq[27:152]);
    rdc(`MHB_ADR_STAT, 32'h996, "stat_full");
    rdc(`MHB_ADR_DROP, 32'h3, "drop");
    rdc(`MHB_ADR_EVT, 32'h1, "evt_ovf");
    wb(1'b1, `MHB_ADR_EVT, 32'h1, 4'hF);
    rdc(`MHB_ADR_EVT, 32'h0, "evt_clr");
    wb(1'b1, `MHB_ADR_CTRL, 32'h3, 4'hF);
    chk("permit_full", 1'b0, permit);
    n = 0;
    while (tx_valid !== 1'b0 && n++ < 1000)
    begin
      lf = lfsr(lf);
      tx_ready <= lf[0];
      @(posedge clk_i);
    end
    tx_ready <= 1'b0;
    chk("drained", 0, exp_tx.size());
    rdc(`MHB_ADR_STAT, 32'h800, "stat_empty");
    $display("test buffer done");
    wb(1'b1, `MHB_ADR_CTRL, 32'h1, 4'hF);
    for (int i = 0; i < 5; i++)
    begin
      if (i == 4)
        wb(1'b1, `MHB_ADR_CTRL, 32'h0, 4'hF);
      lf = lfsr(lf);
      if (i < 4)
        exp_resp.push_back(lf[0]);
      @(posedge clk_i);
      tx_ok <= lf[0];
      tx_done <= 1'b1;
      @(posedge clk_i);
      tx_done <= 1'b0;
    end
    repeat (3) @(posedge clk_i);
    chk("resp_left", 0, exp_resp.size());
    $display("test responses done");
    wb(1'b1, `MHB_ADR_CTRL, 32'h1, 4'hF);
    for (int i = 0; i < 3; i++)
    begin
      lf = lfsr(lf);
      if (i < 2)
        exp_ack.push_back(lf[15:8]);
      else
        wb(1'b1, `MHB_ADR_CTRL, 32'h0, 4'hF);
      @(posedge clk_i);
      cmd_valid <= 1'b1;
      cmd_code <= lf[15:8];
      @(posedge clk_i);
      cmd_valid <= 1'b0;
      // The clash command at n 3 must be dropped; the ack is awaited before the next one.
      for (n = 1; n <= 20; n++)
      begin
        @(posedge clk_i);
        cmd_valid <= (n == 3);
        cmd_code <= ~lf[15:8];
        if (ack === 1'b1)
          chk("ack_time", 17, n);
      end
    end
    chk("ack_left", 0, exp_ack.size());
    rdc(`MHB_ADR_EVT, 32'h2, "evt_clash");
    $display("test commands done");
    wb(1'b1, `MHB_ADR_CTRL, 32'h2, 4'hF);
    shut_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("pdown", 3'b100, {pdown, rdy, permit});
    repeat (5) @(posedge clk_i);
    shut_n <= 1'b1;
    n = 0;
    while (rdy !== 1'b1 && n++ < 200)
      @(posedge clk_i);
    chk("wake", 1'b1, n <= WAKE + 3);
    chk("awake", 1'b0, pdown);
    rdc(`MHB_ADR_CTRL, 32'h1, "ctrl_wake");
    $display("test power done");
    complete_run();
  end
endmodule : tb_top
